// ===== lcb_pkg.sv
`default_nettype none
package lcb_pkg;
	// word and address widths of the serial register access
	localparam int LCB_DW = 16;
	localparam int LCB_AW = 7;
	localparam int LCB_NREG = 48;
	localparam int LCB_IW = 6;

	// reset values per register class
	localparam logic [15:0] LCB_GAIN_RESET = 16'hFFFF;
	localparam logic [15:0] LCB_OFFSET_RESET = 16'h8000;
	localparam logic [15:0] LCB_CTRL_RESET = 16'h0000;
	// fixed answer for reserved reads; repeatable, carries no meaning
	localparam logic [15:0] LCB_RSVD_READ = 16'h0000;

	// channel_select encodings
	localparam logic [1:0] LCB_CH_NONE = 2'h0;
	localparam logic [1:0] LCB_CH_0 = 2'h1;
	localparam logic [1:0] LCB_CH_1 = 2'h2;
	localparam logic [1:0] LCB_CH_BOTH = 2'h3;

	typedef enum logic [1:0] {LCB_CTRL, LCB_GAIN, LCB_OFFS} lcb_kind_t;

	typedef struct packed {
		logic [6:0] addr;
		lcb_kind_t kind;
		logic ch0_only;
	} lcb_entry_t;

	// one register access as issued by the serial host side
	typedef struct packed {
		logic wr_en;
		logic rd_en;
		logic [1:0] channel_select;
		logic [6:0] register_address;
		logic [15:0] wr_data;
	} lcb_req_t;

	// address map: register address, class, channel-0-only flag
	localparam lcb_entry_t LCB_MAP [LCB_NREG] = '{
		'{7'h11, LCB_CTRL, 1'b0}, '{7'h12, LCB_CTRL, 1'b1},
		'{7'h34, LCB_OFFS, 1'b0}, '{7'h35, LCB_OFFS, 1'b0}, '{7'h36, LCB_OFFS, 1'b0},
		'{7'h37, LCB_OFFS, 1'b0}, '{7'h38, LCB_OFFS, 1'b0}, '{7'h39, LCB_OFFS, 1'b0},
		'{7'h3A, LCB_OFFS, 1'b0}, '{7'h3B, LCB_OFFS, 1'b1}, '{7'h3C, LCB_OFFS, 1'b1},
		'{7'h3D, LCB_OFFS, 1'b1}, '{7'h3E, LCB_OFFS, 1'b1},
		'{7'h41, LCB_GAIN, 1'b1}, '{7'h42, LCB_GAIN, 1'b0}, '{7'h43, LCB_GAIN, 1'b1},
		'{7'h44, LCB_GAIN, 1'b1}, '{7'h45, LCB_GAIN, 1'b0}, '{7'h46, LCB_GAIN, 1'b0},
		'{7'h47, LCB_GAIN, 1'b0}, '{7'h48, LCB_GAIN, 1'b0}, '{7'h49, LCB_GAIN, 1'b0},
		'{7'h4B, LCB_GAIN, 1'b1}, '{7'h4C, LCB_GAIN, 1'b0}, '{7'h4D, LCB_GAIN, 1'b0},
		'{7'h4E, LCB_GAIN, 1'b0}, '{7'h4F, LCB_GAIN, 1'b0}, '{7'h50, LCB_GAIN, 1'b0},
		'{7'h51, LCB_GAIN, 1'b0}, '{7'h52, LCB_GAIN, 1'b0}, '{7'h53, LCB_GAIN, 1'b0},
		'{7'h54, LCB_GAIN, 1'b0}, '{7'h55, LCB_GAIN, 1'b0}, '{7'h56, LCB_GAIN, 1'b0},
		'{7'h57, LCB_GAIN, 1'b0}, '{7'h58, LCB_GAIN, 1'b0},
		'{7'h59, LCB_OFFS, 1'b1}, '{7'h5A, LCB_OFFS, 1'b0}, '{7'h5B, LCB_OFFS, 1'b1},
		'{7'h5C, LCB_OFFS, 1'b1}, '{7'h5D, LCB_OFFS, 1'b0}, '{7'h5E, LCB_OFFS, 1'b0},
		'{7'h63, LCB_OFFS, 1'b1}, '{7'h64, LCB_OFFS, 1'b0}, '{7'h65, LCB_OFFS, 1'b0},
		'{7'h6A, LCB_OFFS, 1'b0}, '{7'h6B, LCB_OFFS, 1'b0}, '{7'h6C, LCB_OFFS, 1'b0}
	};

	// reset value of a register class
	function automatic logic [15:0] lcb_reset_of(input lcb_kind_t kind);
		unique case (kind)
			LCB_GAIN: return LCB_GAIN_RESET;
			LCB_OFFS: return LCB_OFFSET_RESET;
			default: return LCB_CTRL_RESET;
		endcase
	endfunction : lcb_reset_of
endpackage : lcb_pkg
`default_nettype wire

// ===== lcb_coef_word.sv
`default_nettype none
module lcb_coef_word
	import lcb_pkg::*;
#(
	parameter logic [15:0] RESET_VAL = LCB_CTRL_RESET
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic wr_en,
	input wire logic [15:0] wr_data,
	output logic [15:0] q_ff
);
	// one stored coefficient word; reserved bits do not exist here
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			q_ff <= RESET_VAL;
		end else if (wr_en) begin
			q_ff <= wr_data;
		end
	end
endmodule : lcb_coef_word
`default_nettype wire

// ===== lcb_addr_decode.sv
`default_nettype none
module lcb_addr_decode
	import lcb_pkg::*;
(
	input wire logic [6:0] register_address,
	output logic hit,
	output logic [5:0] idx,
	output logic ch0_only
);
	logic [LCB_NREG-1:0] match;

	// one comparator per map entry
	for (genvar g = 0; g < LCB_NREG; g++) begin : g_match
		assign match[g] = (register_address == LCB_MAP[g].addr);
	end

	// encode the single match; addresses in the map are unique
	always_comb begin
		hit = 1'b0;
		idx = 6'h00;
		ch0_only = 1'b0;
		for (int i = 0; i < LCB_NREG; i++) begin
			if (match[i]) begin
				hit = 1'b1;
				idx = 6'(i);
				ch0_only = LCB_MAP[i].ch0_only;
			end
		end
	end
endmodule : lcb_addr_decode
`default_nettype wire

// ===== lcb_coef_bank.sv
`default_nettype none
// Summary of operation
// - each per-channel register has one copy per channel, chosen by channel_select.
// - every gain coefficient register resets to all ones.
// - every offset coefficient register resets to 0x8000.
// - force-current ranges A to E own gains 0x54-0x58, one shared offset 0x6C.
// - measure-current levels share one offset each: high 0x5E, low 0x65.
// - writes to reserved bits or addresses change nothing.
// - reserved reads return a fixed meaningless value.
// - a channel-1-only write to a channel-0-only register is ignored.
// - a both-channel write to a channel-0-only register updates channel 0 only.
// - offsets at 0x59, 0x5B, 0x5C, 0x63 exist on channel 0 only.
module lcb_coef_bank
	import lcb_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst,
	input wire lcb_req_t req,
	output logic [15:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic [LCB_NREG-1:0][15:0] coef_ch0,
	output logic [LCB_NREG-1:0][15:0] coef_ch1
);
	logic dec_hit;
	logic [5:0] dec_idx;
	logic dec_ch0_only;
	logic wr_ch0;
	logic wr_ch1;
	logic [15:0] nxt_rd_data;

	lcb_addr_decode u_decode (
		.register_address(req.register_address),
		.hit(dec_hit),
		.idx(dec_idx),
		.ch0_only(dec_ch0_only)
	);

	// unmapped addresses never enable a write
	assign wr_ch0 = req.wr_en & dec_hit & req.channel_select[0];
	// channel 1 strobe is dropped where no channel 1 copy exists
	assign wr_ch1 = req.wr_en & dec_hit & req.channel_select[1] & ~dec_ch0_only;

	// storage: channel 0 always, channel 1 only where it is defined
	for (genvar g = 0; g < LCB_NREG; g++) begin : g_word
		lcb_coef_word #(
			.RESET_VAL(lcb_reset_of(LCB_MAP[g].kind))
		) u_ch0 (
			.ref_clk(ref_clk),
			.rst(rst),
			.wr_en(wr_ch0 && (dec_idx == 6'(g))),
			.wr_data(req.wr_data),
			.q_ff(coef_ch0[g])
		);
		if (LCB_MAP[g].ch0_only) begin : g_no_ch1
			// no channel 1 storage, its data is discarded
			assign coef_ch1[g] = LCB_RSVD_READ;
		end else begin : g_ch1
			lcb_coef_word #(
				.RESET_VAL(lcb_reset_of(LCB_MAP[g].kind))
			) u_ch1 (
				.ref_clk(ref_clk),
				.rst(rst),
				.wr_en(wr_ch1 && (dec_idx == 6'(g))),
				.wr_data(req.wr_data),
				.q_ff(coef_ch1[g])
			);
		end
	end

	// read select; a read sharing a cycle with a write sees the old word
	always_comb begin
		nxt_rd_data = LCB_RSVD_READ;
		if (dec_hit) begin
			if (req.channel_select[0]) begin
				// both channels selected reads channel 0, the only copy always present
				nxt_rd_data = coef_ch0[dec_idx];
			end else if (req.channel_select[1] && !dec_ch0_only) begin
				nxt_rd_data = coef_ch1[dec_idx];
			end
		end
	end

	// read data register, fixed value for anything reserved
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_data_ff <= LCB_RSVD_READ;
		end else if (req.rd_en) begin
			rd_data_ff <= nxt_rd_data;
		end
	end

	// read answer strobe, one cycle per accepted read
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			rd_valid_ff <= 1'b0;
		end else begin
			rd_valid_ff <= req.rd_en;
		end
	end

	// ------------------------------------------------------------------
	// checking helpers: the previous request, and words not yet written
	// ------------------------------------------------------------------
	logic h_wr_ff;
	logic h_rd_ff;
	logic h_hit_ff;
	logic h_c0o_ff;
	logic [1:0] h_ch_ff;
	logic [5:0] h_idx_ff;
	logic [15:0] h_data_ff;
	logic [15:0] h_old0_ff;
	logic [15:0] h_old1_ff;
	logic [LCB_NREG-1:0] touched0_ff;
	logic [LCB_NREG-1:0] touched1_ff;

	// capture of the last request and the words it addressed
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			h_wr_ff <= 1'b0;
			h_rd_ff <= 1'b0;
			h_hit_ff <= 1'b0;
			h_c0o_ff <= 1'b0;
			h_ch_ff <= LCB_CH_NONE;
			h_idx_ff <= 6'h00;
			h_data_ff <= 16'h0000;
			h_old0_ff <= 16'h0000;
			h_old1_ff <= 16'h0000;
		end else begin
			h_wr_ff <= req.wr_en;
			h_rd_ff <= req.rd_en;
			h_hit_ff <= dec_hit;
			h_c0o_ff <= dec_ch0_only;
			h_ch_ff <= req.channel_select;
			h_idx_ff <= dec_idx;
			h_data_ff <= req.wr_data;
			h_old0_ff <= coef_ch0[dec_idx];
			h_old1_ff <= coef_ch1[dec_idx];
		end
	end

	// words that have taken a write since reset
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			touched0_ff <= '0;
			touched1_ff <= '0;
		end else begin
			if (wr_ch0) begin
				touched0_ff[dec_idx] <= 1'b1;
			end
			if (wr_ch1) begin
				touched1_ff[dec_idx] <= 1'b1;
			end
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	// reset values hold until the first write of each gain and offset word and each channel 1 copy
	for (genvar g = 0; g < LCB_NREG; g++) begin : g_chk
		if (LCB_MAP[g].kind == LCB_GAIN) begin : g_gain
			gain_reset_a: assert property (!touched0_ff[g] |-> coef_ch0[g] == LCB_GAIN_RESET)
				else $error("gain coefficient left its reset value without a write");
		end
		if (LCB_MAP[g].kind == LCB_OFFS) begin : g_offs
			offset_reset_a: assert property (!touched0_ff[g] |-> coef_ch0[g] == LCB_OFFSET_RESET)
				else $error("offset coefficient left its reset value without a write");
		end
		if (!LCB_MAP[g].ch0_only) begin : g_c1
			ch1_reset_a: assert property (!touched1_ff[g] |-> coef_ch1[g] == lcb_reset_of(LCB_MAP[g].kind))
				else $error("channel 1 copy left its reset value without a write");
		end
	end

	// a write lands in channel 0 on the next cycle
	write_lands_a: assert property (h_wr_ff && h_hit_ff && h_ch_ff[0] |-> coef_ch0[h_idx_ff] == h_data_ff)
		else $error("channel 0 word does not hold the written data");

	// a channel-0-only selection leaves the channel 1 copy alone
	chan_separate_a: assert property (h_wr_ff && h_hit_ff && h_ch_ff == LCB_CH_0 |-> coef_ch1[h_idx_ff] == h_old1_ff)
		else $error("channel 1 copy changed by a channel 0 write");

	// channel-1-only write to a channel-0-only word is ignored
	ch1_ignored_a: assert property (h_wr_ff && h_c0o_ff && h_ch_ff == LCB_CH_1 |-> coef_ch0[h_idx_ff] == h_old0_ff)
		else $error("channel-0-only word changed by a channel 1 write");

	// both-channel write to a channel-0-only word updates channel 0 only
	both_to_ch0_a: assert property (h_wr_ff && h_hit_ff && h_c0o_ff && h_ch_ff == LCB_CH_BOTH
		|-> coef_ch0[h_idx_ff] == h_data_ff && coef_ch1[h_idx_ff] == LCB_RSVD_READ)
		else $error("both-channel write to channel-0-only word mishandled");

	// writes to reserved addresses leave every word stable
	rsvd_write_a: assert property (req.wr_en && !dec_hit |=> $stable(coef_ch0) && $stable(coef_ch1))
		else $error("reserved address write changed stored state");

	// reserved reads answer the fixed value one cycle later
	rsvd_read_a: assert property (req.rd_en && !dec_hit |=> rd_valid_ff && rd_data_ff == LCB_RSVD_READ)
		else $error("reserved read returned something other than the fixed value");

	// the same reserved read twice, one idle cycle apart, gives the same answer
	rsvd_repeat_a: assert property (req.rd_en && !dec_hit ##2 req.rd_en && !dec_hit |=> $stable(rd_data_ff))
		else $error("reserved read is not repeatable");

	// a mapped channel 0 read returns the stored word
	read_back_a: assert property (h_rd_ff && h_hit_ff && h_ch_ff[0] |-> rd_valid_ff && rd_data_ff == h_old0_ff)
		else $error("read data does not match the stored channel 0 word");

	// force-current gains and shared offset are mapped on both channels
	force_cur_map_a: assert property (((req.register_address >= 7'h54 && req.register_address <= 7'h58)
		|| req.register_address == 7'h6C) |-> dec_hit && !dec_ch0_only)
		else $error("force-current coefficient not mapped per channel");

	// measure-current shared offsets are per-channel registers
	meas_cur_offs_a: assert property ((req.register_address == 7'h5E || req.register_address == 7'h65)
		|-> dec_hit && !dec_ch0_only)
		else $error("measure-current shared offset mapped wrongly");

	// high-voltage and differential offsets are channel 0 only
	ch0_only_map_a: assert property ((req.register_address == 7'h59 || req.register_address == 7'h5B
		|| req.register_address == 7'h5C || req.register_address == 7'h63) |-> dec_hit && dec_ch0_only)
		else $error("channel-0-only offset mapped to channel 1");

	// main scenarios for coverage
	both_write_c: cover property (req.wr_en && dec_hit && !dec_ch0_only && req.channel_select == LCB_CH_BOTH);
	ch1_drop_c: cover property (req.wr_en && dec_ch0_only && req.channel_select == LCB_CH_1);
	rsvd_read_c: cover property (req.rd_en && !dec_hit);
	write_then_read_c: cover property (req.wr_en && dec_hit ##2 req.rd_en && dec_hit);
endmodule : lcb_coef_bank
`default_nettype wire

// ===== lcb_host_model.sv
`default_nettype none
// stands in for the serial host controller: one 16-bit word per access
module lcb_host_model
	import lcb_pkg::*;
(
	input wire logic ref_clk,
	output var lcb_req_t req,
	input wire logic [15:0] rd_data_ff,
	input wire logic rd_valid_ff
);
	timeunit 1ns;
	timeprecision 1ps;

	// quiet bus from time zero
	initial begin
		req = '0;
	end

	// channel_select goes out exactly as the caller gives it, none and both included
	// one word access: strobes stand one cycle, answer taken one edge later
	task automatic access(input logic w, input logic r, input logic [1:0] ch, input logic [6:0] a,
			input logic [15:0] d, output logic [15:0] q, output logic v);
		@(posedge ref_clk);
		req <= '{wr_en: w, rd_en: r, channel_select: ch, register_address: a, wr_data: d};
		@(posedge ref_clk);
		// released lines show the inverse so a stale value never passes for a held one
		req <= '{wr_en: 1'b0, rd_en: 1'b0, channel_select: ~ch, register_address: ~a, wr_data: ~d};
		#1;
		q = rd_data_ff;
		v = rd_valid_ff;
	endtask : access
endmodule : lcb_host_model
`default_nettype wire

// ===== test_lcb_coef_bank.sv
`default_nettype none
`define CHK(got, exp) begin checks_done++; if ((got) !== (exp)) begin mismatches++; $display("BAD t=%0t got %h expected %h", $time, got, exp); end end
module test_lcb_coef_bank
	import lcb_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic ref_clk;
	logic rst;
	lcb_req_t req;
	logic [15:0] rd_data_ff;
	logic rd_valid_ff;
	int mismatches;
	int checks_done;
	logic [15:0] q;
	logic v;
	logic [15:0] exp0 [128];
	logic [15:0] exp1 [128];
	logic [LCB_NREG-1:0][15:0] coef_ch0;
	logic [LCB_NREG-1:0][15:0] coef_ch1;

	lcb_coef_bank u_lcb_coef_bank (.ref_clk(ref_clk), .rst(rst), .req(req), .rd_data_ff(rd_data_ff),
		.rd_valid_ff(rd_valid_ff), .coef_ch0(coef_ch0), .coef_ch1(coef_ch1));
	lcb_host_model u_lcb_host_model (.ref_clk(ref_clk), .req(req), .rd_data_ff(rd_data_ff),
		.rd_valid_ff(rd_valid_ff));

	// 125 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end

	// addresses that hold storage, written out from the register table
	function automatic logic mapped(input logic [6:0] a);
		return a == 7'h11 || a == 7'h12 || (a >= 7'h34 && a <= 7'h3E) || (a >= 7'h41 && a <= 7'h5E && a != 7'h4A)
			|| (a >= 7'h63 && a <= 7'h65) || (a >= 7'h6A && a <= 7'h6C);
	endfunction : mapped

	// registers that have no channel 1 copy
	function automatic logic ch0only(input logic [6:0] a);
		return a == 7'h12 || (a >= 7'h3B && a <= 7'h3E) || a == 7'h41 || a == 7'h43 || a == 7'h44
			|| a == 7'h4B || a == 7'h59 || a == 7'h5B || a == 7'h5C || a == 7'h63;
	endfunction : ch0only

	// gains reset to all ones, offsets to mid-scale, control words and holes read zero
	function automatic logic [15:0] rst_val(input logic [6:0] a);
		if (!mapped(a)) return 16'h0000;
		if (a >= 7'h41 && a <= 7'h58) return 16'hFFFF;
		return (a >= 7'h34) ? 16'h8000 : 16'h0000;
	endfunction : rst_val

	// distinct word per address and pass, so aliasing shows up
	function automatic logic [15:0] pat(input logic [6:0] a, input logic [1:0] k);
		return {k, a, a};
	endfunction : pat

	task automatic wr(input logic [1:0] ch, input logic [6:0] a, input logic [15:0] dat);
		u_lcb_host_model.access(1'b1, 1'b0, ch, a, dat, q, v);
		`CHK(v, 1'b0)
	endtask : wr

	task automatic rd(input logic [1:0] ch, input logic [6:0] a, input logic [15:0] e);
		u_lcb_host_model.access(1'b0, 1'b1, ch, a, ~e, q, v);
		`CHK(v, 1'b1)
		`CHK(q, e)
	endtask : rd

	// every stored word as seen on the coefficient outputs, against the expected image
	task automatic chk_coef();
		for (int g = 0; g < LCB_NREG; g++) begin
			`CHK(coef_ch0[g], exp0[LCB_MAP[g].addr])
			`CHK(coef_ch1[g], exp1[LCB_MAP[g].addr])
		end
	endtask : chk_coef

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		rst = 1'b1;
		mismatches = 0;
		checks_done = 0;
		repeat (20) @(posedge ref_clk);
		rst <= 1'b0;
		for (int a = 0; a < 128; a++) begin
			exp0[a] = rst_val(7'(a));
			exp1[a] = ch0only(7'(a)) ? 16'h0000 : exp0[a];
			rd(LCB_CH_0, 7'(a), exp0[a]);
			rd(LCB_CH_1, 7'(a), exp1[a]);
		end
		chk_coef();
		$display("test reset_values done");
		for (int a = 0; a < 128; a++) begin
			wr(LCB_CH_BOTH, 7'(a), pat(7'(a), 2'h1));
			wr(LCB_CH_1, 7'(a), pat(7'(a), 2'h2));
			wr(LCB_CH_NONE, 7'(a), pat(7'(a), 2'h3));
			if (mapped(7'(a))) begin
				exp0[a] = pat(7'(a), 2'h1);
				exp1[a] = ch0only(7'(a)) ? 16'h0000 : pat(7'(a), 2'h2);
			end
		end
		chk_coef();
		for (int a = 0; a < 128; a++) begin
			rd(LCB_CH_0, 7'(a), exp0[a]);
			rd(LCB_CH_1, 7'(a), exp1[a]);
			rd(LCB_CH_BOTH, 7'(a), exp0[a]);
		end
		$display("test channel_writes done");
		// a write and read taken together answer with the word from before the write
		u_lcb_host_model.access(1'b1, 1'b1, LCB_CH_0, 7'h6C, 16'h1234, q, v);
		`CHK(q, exp0[7'h6C])
		rd(LCB_CH_0, 7'h6C, 16'h1234);
		rd(LCB_CH_1, 7'h6C, exp1[7'h6C]);
		$display("test same_cycle done");
		// a second reset in mid-run brings every class back
		rst <= 1'b1;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		rd(LCB_CH_0, 7'h58, 16'hFFFF);
		rd(LCB_CH_1, 7'h65, 16'h8000);
		rd(LCB_CH_0, 7'h12, 16'h0000);
		$display("test second_reset done");
		end_of_test();
	end

	// tests take about 2100 cycles; the limit leaves a wide margin
	initial begin
		repeat (20000) @(posedge ref_clk);
		mismatches++;
		$display("BAD t=%0t watchdog expired", $time);
		end_of_test();
	end
endmodule : test_lcb_coef_bank
`undef CHK
`default_nettype wire
